// file: design/sfr_core.sv
// module: special function register core of an 8-bit controller
// Contract
// - reserved gap below general memory reads zero
// - indirect port access goes to pointed location
// - first pointer bank 0, second also bank 0
// - pointer at indirect port: read zero, no write
// - pointers are ordinary read/write registers
// - working register holds alu results, moves
// - low byte write jumps within current page
// - low byte jump inserts one dummy cycle
// - table read: high byte kept, low to destination
// - table address from both pointers or pc
// - flag writes leave watchdog and sleep flags
// - carry on add carry, sub no borrow, rotate
// - half carry from low nibble on add and sub only
// - zero flag follows result zero
// - overflow is carry in xor carry out
// - sleep flag: cleared by kick, set by halt
// - watchdog flag: set only by time-out
// - status never pushed on call or interrupt
// - per-source enables plus global gate
// - gate cleared on entry, set on return
// - timer overflow is an interrupt source
`timescale 1ns/1ps
module sfr_core import sfr_pkg::*; (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire sfr_acc_t acc_i,
    input wire logic dst_wreg_i,
    input wire sfr_alu_t alu_i,
    input wire logic [PC_W-1:0] pc_i,
    input wire logic pc_inc_i,
    input wire logic table_fetch_cmd_i,
    input wire logic [7:0] table_dst_i,
    input wire logic table_dst_wreg_i,
    input wire logic [14:0] rom_data_i,
    input wire logic rom_valid_i,
    input wire logic table_pointer_high_enable_i,
    input wire logic watchdog_kick_op_i,
    input wire logic halt_op_i,
    input wire logic watchdog_timeout_i,
    input wire logic irq_enter_i,
    input wire logic irq_return_op_i,
    input wire logic timer_overflow_i,
    input wire logic [7:0] ram_rdata_i,
    output logic [7:0] rdata_o,
    output logic [7:0] working_register_o,
    output logic [7:0] flags_o,
    output logic [PC_W-1:0] pc_o,
    output logic pc_load_o,
    output logic dummy_cycle_o,
    output logic [PC_W-1:0] rom_addr_o,
    output logic rom_rd_o,
    output logic ram_rd_o,
    output logic ram_wr_o,
    output logic [BANK_W-1:0] ram_bank_o,
    output logic [7:0] ram_addr_o,
    output logic [7:0] ram_wdata_o,
    output logic irq_req_o,
    output logic push_status_o
);
    typedef enum logic [2:0] {
        SFR_TB_IDLE = 3'b001,
        SFR_TB_WAIT = 3'b010,
        SFR_TB_DONE = 3'b100
    } sfr_tb_state_t;

    logic [7:0] pointer_zero_r;
    logic [7:0] pointer_one_r;
    logic [7:0] working_register_r;
    logic [7:0] table_pointer_low_r;
    logic [7:0] table_pointer_high_r;
    logic [7:0] table_data_high_r;
    logic [7:0] flags_r;
    logic [7:0] irq_gate_register_r;
    logic [7:0] rdata_r;
    logic [PC_W-1:0] pc_r;
    logic pc_load_r;
    logic dummy_cycle_r;
    logic [PC_W-1:0] rom_addr_r;
    logic rom_rd_r;
    logic ram_rd_r;
    logic ram_wr_r;
    logic [BANK_W-1:0] ram_bank_r;
    logic [7:0] ram_addr_r;
    logic [7:0] ram_wdata_r;
    logic irq_req_r;
    logic timer_pend_r;
    logic [7:0] tb_dst_r;
    logic tb_dst_w_r;
    sfr_tb_state_t tb_state_r;
    sfr_tb_state_t tb_state_nxt;

    logic [3:0] alu_flags;
    logic is_ind0;
    logic is_ind1;
    logic [7:0] ind_addr;
    logic ind_self;
    logic [7:0] eff_addr;
    logic is_ram;
    logic is_sfr_gap;
    logic [7:0] sfr_rd;
    logic wr_sfr;
    logic tb_load;

    sfr_flag_calc u_flag_calc (
        .alu_i(alu_i),
        .flags_o(alu_flags)
    );

    // decode indirect access and resolve the effective address
    always_comb begin
        is_ind0 = (acc_i.addr == ADR_IND0);
        is_ind1 = (acc_i.addr == ADR_IND1);
        ind_addr = is_ind1 ? pointer_one_r : pointer_zero_r;
        ind_self = (is_ind0 || is_ind1) &&
            (ind_addr == ADR_IND0 || ind_addr == ADR_IND1);
        eff_addr = (is_ind0 || is_ind1) ? ind_addr : acc_i.addr;
        is_ram = (eff_addr >= ADR_GP_BASE);
        is_sfr_gap = !is_ram && (eff_addr > ADR_SFR_END);
        wr_sfr = acc_i.wr && !is_ram && !ind_self;
        tb_load = (tb_state_r == SFR_TB_WAIT) && rom_valid_i;
    end

    // read mux for special registers; unused locations give zero
    always_comb begin
        unique case (eff_addr)
            ADR_PTR0: sfr_rd = pointer_zero_r;
            ADR_PTR1: sfr_rd = pointer_one_r;
            ADR_WREG: sfr_rd = working_register_r;
            ADR_PCLB: sfr_rd = pc_r[7:0];
            ADR_TPLO: sfr_rd = table_pointer_low_r;
            ADR_TDHI: sfr_rd = table_data_high_r;
            ADR_FLAG: sfr_rd = flags_r;
            ADR_IRQG: sfr_rd = irq_gate_register_r;
            ADR_TPHI: sfr_rd = table_pointer_high_r;
            default: sfr_rd = ZERO_BYTE;
        endcase
    end

    // read data: self-pointing indirect and reserved gap give zero
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            rdata_r <= RST_BYTE;
        end else if (acc_i.rd) begin
            if (ind_self || is_sfr_gap) begin
                rdata_r <= ZERO_BYTE;
            end else if (is_ram) begin
                rdata_r <= ram_rdata_i;
            end else begin
                rdata_r <= sfr_rd;
            end
        end
    end

    // general memory strobes; first pointer held to bank 0
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            ram_rd_r <= 1'b0;
            ram_wr_r <= 1'b0;
            ram_bank_r <= BANK0;
            ram_addr_r <= RST_BYTE;
            ram_wdata_r <= RST_BYTE;
        end else begin
            ram_rd_r <= acc_i.rd && is_ram && !ind_self;
            ram_wr_r <= (acc_i.wr && is_ram && !ind_self) ||
                (tb_load && !tb_dst_w_r && tb_dst_r >= ADR_GP_BASE);
            ram_bank_r <= BANK0;
            if (is_ind1) begin
                ram_bank_r <= pointer_one_r[7:8-BANK_W] & {BANK_W{1'b0}};
            end
            ram_addr_r <= tb_load ? tb_dst_r : eff_addr;
            ram_wdata_r <= tb_load ? rom_data_i[7:0] : acc_i.wdata;
        end
    end

    // memory pointers
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            pointer_zero_r <= RST_BYTE;
            pointer_one_r <= RST_BYTE;
        end else if (wr_sfr) begin
            if (eff_addr == ADR_PTR0) pointer_zero_r <= acc_i.wdata;
            if (eff_addr == ADR_PTR1) pointer_one_r <= acc_i.wdata;
        end
    end

    // working register takes alu results and move data
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            working_register_r <= RST_BYTE;
        end else if (tb_load && tb_dst_w_r) begin
            working_register_r <= rom_data_i[7:0];
        end else if (alu_i.valid && dst_wreg_i) begin
            working_register_r <= alu_i.res;
        end else if (wr_sfr && eff_addr == ADR_WREG) begin
            working_register_r <= acc_i.wdata;
        end
    end

    // table pointers
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            table_pointer_low_r <= RST_BYTE;
            table_pointer_high_r <= RST_BYTE;
        end else if (wr_sfr) begin
            if (eff_addr == ADR_TPLO) table_pointer_low_r <= acc_i.wdata;
            if (eff_addr == ADR_TPHI) table_pointer_high_r <= acc_i.wdata;
        end
    end

    // table read sequencer state
    always_comb begin
        tb_state_nxt = tb_state_r;
        unique case (tb_state_r)
            SFR_TB_IDLE: if (table_fetch_cmd_i) tb_state_nxt = SFR_TB_WAIT;
            SFR_TB_WAIT: if (rom_valid_i) tb_state_nxt = SFR_TB_DONE;
            SFR_TB_DONE: tb_state_nxt = SFR_TB_IDLE;
            default: tb_state_nxt = SFR_TB_IDLE;
        endcase
    end

    // table read: address, destination capture and high byte
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            tb_state_r <= SFR_TB_IDLE;
            rom_rd_r <= 1'b0;
            rom_addr_r <= '0;
            tb_dst_r <= RST_BYTE;
            tb_dst_w_r <= 1'b0;
            table_data_high_r <= RST_BYTE;
        end else begin
            tb_state_r <= tb_state_nxt;
            rom_rd_r <= (tb_state_r == SFR_TB_IDLE) && table_fetch_cmd_i;
            if ((tb_state_r == SFR_TB_IDLE) && table_fetch_cmd_i) begin
                tb_dst_r <= table_dst_i;
                tb_dst_w_r <= table_dst_wreg_i;
                if (table_pointer_high_enable_i) begin
                    rom_addr_r <= {table_pointer_high_r[PC_W-9:0],
                        table_pointer_low_r};
                end else begin
                    rom_addr_r <= {pc_r[PC_W-1:8],
                        table_pointer_low_r};
                end
            end
            if (tb_load) begin
                table_data_high_r <= {1'b0, rom_data_i[14:8]};
            end
        end
    end

    // program counter, low byte write jumps in page with a dummy cycle
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            pc_r <= '0;
            pc_load_r <= 1'b0;
            dummy_cycle_r <= 1'b0;
        end else begin
            pc_load_r <= 1'b0;
            dummy_cycle_r <= 1'b0;
            if (wr_sfr && eff_addr == ADR_PCLB) begin
                pc_r <= {pc_r[PC_W-1:8], acc_i.wdata};
                pc_load_r <= 1'b1;
                dummy_cycle_r <= 1'b1;
            end else if (pc_inc_i) begin
                pc_r <= pc_i;
            end
        end
    end

    // flags: arithmetic from alu or writes; system flags own sources
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            flags_r <= RST_BYTE;
        end else begin
            if (alu_i.valid) begin
                flags_r[FLG_Z] <= alu_flags[FLG_Z];
                if (alu_i.op == SFR_OP_ADD || alu_i.op == SFR_OP_SUB) begin
                    flags_r[FLG_C] <= alu_flags[FLG_C];
                    flags_r[FLG_HC] <= alu_flags[FLG_HC];
                    flags_r[FLG_OV] <= alu_flags[FLG_OV];
                end else if (alu_i.op == SFR_OP_ROT) begin
                    flags_r[FLG_C] <= alu_flags[FLG_C];
                end
            end else if (wr_sfr && eff_addr == ADR_FLAG) begin
                flags_r[3:0] <= acc_i.wdata[3:0] & FLG_ARITH_MASK[3:0];
            end
            if (watchdog_kick_op_i) begin
                flags_r[FLG_SLP] <= 1'b0;
            end else if (halt_op_i) begin
                flags_r[FLG_SLP] <= 1'b1;
            end
            if (watchdog_timeout_i) begin
                flags_r[FLG_WDX] <= 1'b1;
            end else if (watchdog_kick_op_i || halt_op_i) begin
                flags_r[FLG_WDX] <= 1'b0;
            end
        end
    end

    // interrupt gate register with automatic gate clear and restore
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            irq_gate_register_r <= RST_BYTE;
        end else begin
            if (wr_sfr && eff_addr == ADR_IRQG) begin
                irq_gate_register_r <= acc_i.wdata;
            end
            if (irq_enter_i) begin
                irq_gate_register_r[IRQ_GATE] <= 1'b0;
            end else if (irq_return_op_i) begin
                irq_gate_register_r[IRQ_GATE] <= 1'b1;
            end
        end
    end

    // timer overflow pending; a new event wins over entry clear
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            timer_pend_r <= 1'b0;
            irq_req_r <= 1'b0;
        end else begin
            if (timer_overflow_i) begin
                timer_pend_r <= 1'b1;
            end else if (irq_enter_i) begin
                timer_pend_r <= 1'b0;
            end
            irq_req_r <= timer_pend_r && !irq_enter_i &&
                irq_gate_register_r[IRQ_GATE] &&
                irq_gate_register_r[IRQ_TMR_EN];
        end
    end

    assign rdata_o = rdata_r;
    assign working_register_o = working_register_r;
    assign flags_o = flags_r;
    assign pc_o = pc_r;
    assign pc_load_o = pc_load_r;
    assign dummy_cycle_o = dummy_cycle_r;
    assign rom_addr_o = rom_addr_r;
    assign rom_rd_o = rom_rd_r;
    assign ram_rd_o = ram_rd_r;
    assign ram_wr_o = ram_wr_r;
    assign ram_bank_o = ram_bank_r;
    assign ram_addr_o = ram_addr_r;
    assign ram_wdata_o = ram_wdata_r;
    assign irq_req_o = irq_req_r;
    // status is never stacked; only the return address is pushed
    assign push_status_o = 1'b0;
endmodule : sfr_core

// file: design/sfr_flag_calc.sv
// module: arithmetic flag computation for one alu step
`timescale 1ns/1ps
module sfr_flag_calc import sfr_pkg::*; (
    input wire sfr_alu_t alu_i,
    output logic [3:0] flags_o
);
    logic c7;
    logic c8;
    logic h4;
    logic [8:0] sum9;
    logic [4:0] sum5;
    logic [7:0] opb;
    logic cin;

    // subtraction is addition of the inverse plus one, so carry means no borrow
    always_comb begin
        opb = (alu_i.op == SFR_OP_SUB) ? ~alu_i.b : alu_i.b;
        cin = (alu_i.op == SFR_OP_SUB);
        sum9 = {1'b0, alu_i.a} + {1'b0, opb} + {8'h00, cin};
        sum5 = {1'b0, alu_i.a[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin};
        h4 = sum5[4];
        c8 = sum9[8];
        c7 = alu_i.a[7] ^ opb[7] ^ sum9[7];
        flags_o = 4'h0;
        flags_o[FLG_Z] = (alu_i.res == ZERO_BYTE);
        if (alu_i.op == SFR_OP_ADD || alu_i.op == SFR_OP_SUB) begin
            flags_o[FLG_C] = c8;
            flags_o[FLG_HC] = h4;
            flags_o[FLG_OV] = c7 ^ c8;
        end else if (alu_i.op == SFR_OP_ROT) begin
            flags_o[FLG_C] = alu_i.cout;
        end
    end
endmodule : sfr_flag_calc

// file: design/sfr_pkg.sv
// package: special function register core addresses, fields and types
package sfr_pkg;
    // data memory addresses of the special function registers
    localparam logic [7:0] ADR_IND0 = 8'h00;
    localparam logic [7:0] ADR_PTR0 = 8'h01;
    localparam logic [7:0] ADR_IND1 = 8'h02;
    localparam logic [7:0] ADR_PTR1 = 8'h03;
    localparam logic [7:0] ADR_WREG = 8'h05;
    localparam logic [7:0] ADR_PCLB = 8'h06;
    localparam logic [7:0] ADR_TPLO = 8'h07;
    localparam logic [7:0] ADR_TDHI = 8'h08;
    localparam logic [7:0] ADR_FLAG = 8'h0A;
    localparam logic [7:0] ADR_IRQG = 8'h0B;
    localparam logic [7:0] ADR_TPHI = 8'h1F;
    // end of special area and start of general purpose memory
    localparam logic [7:0] ADR_SFR_END = 8'h24;
    localparam logic [7:0] ADR_GP_BASE = 8'h40;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    // flags register bit positions
    localparam int FLG_C = 0;
    localparam int FLG_HC = 1;
    localparam int FLG_Z = 2;
    localparam int FLG_OV = 3;
    localparam int FLG_SLP = 4;
    localparam int FLG_WDX = 5;
    // irq gate register bit positions
    localparam int IRQ_GATE = 0;
    localparam int IRQ_TMR_EN = 2;
    localparam logic [7:0] FLG_ARITH_MASK = 8'h0F;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam int PC_W = 12;
    localparam int BANK_W = 1;
    localparam logic [BANK_W-1:0] BANK0 = 1'b0;

    // alu operation classes
    typedef enum logic [2:0] {
        SFR_OP_NONE = 3'h0,
        SFR_OP_ADD = 3'h1,
        SFR_OP_SUB = 3'h2,
        SFR_OP_LOGIC = 3'h3,
        SFR_OP_ROT = 3'h4
    } sfr_op_t;

    // result of one alu step offered for flag update
    typedef struct packed {
        logic valid;
        sfr_op_t op;
        logic [7:0] a;
        logic [7:0] b;
        logic [7:0] res;
        logic cout;
    } sfr_alu_t;

    // one data memory access from the core
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sfr_acc_t;
endpackage : sfr_pkg

// file: testbench/sfr_core_chk.sv
// checker: timing relations at the register core ports
`timescale 1ns/1ps
module sfr_core_chk import sfr_pkg::*; (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire sfr_acc_t acc_i,
    input wire sfr_alu_t alu_i,
    input wire logic pc_inc_i,
    input wire logic watchdog_kick_op_i,
    input wire logic halt_op_i,
    input wire logic watchdog_timeout_i,
    input wire logic irq_enter_i,
    input wire logic irq_return_op_i,
    input wire logic [7:0] rdata_o,
    input wire logic [7:0] flags_o,
    input wire logic [PC_W-1:0] pc_o,
    input wire logic pc_load_o,
    input wire logic dummy_cycle_o,
    input wire logic ram_wr_o,
    input wire logic [BANK_W-1:0] ram_bank_o,
    input wire logic [7:0] ram_wdata_o,
    input wire logic irq_req_o,
    input wire logic push_status_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    // low byte jumps, page kept, one dummy cycle
    pcl_jump_a: assert property (
        acc_i.wr && acc_i.addr == ADR_PCLB && !pc_inc_i |=> pc_load_o
        && pc_o[7:0] == $past(acc_i.wdata)) else $error("bad jump");
    page_keep_a: assert property (
        acc_i.wr && acc_i.addr == ADR_PCLB && !pc_inc_i
        |=> $stable(pc_o[PC_W-1:8])) else $error("page changed");
    dummy_once_a: assert property (
        acc_i.wr && acc_i.addr == ADR_PCLB ##1
        !(acc_i.wr && acc_i.addr == ADR_PCLB)
        |-> dummy_cycle_o ##1 !dummy_cycle_o) else $error("bad dummy");
    // reserved gap and indirect bank
    gap_zero_a: assert property (
        acc_i.rd && acc_i.addr inside {[8'h25:8'h3F]}
        |=> rdata_o == ZERO_BYTE) else $error("gap not zero");
    ind_bank_a: assert property (
        acc_i.wr && acc_i.addr == ADR_IND0 ##1 ram_wr_o
        |-> ram_bank_o == BANK0 && ram_wdata_o == $past(acc_i.wdata))
        else $error("bad indirect write");
    // system flags and zero flag
    wdx_keep_a: assert property (
        !watchdog_timeout_i && !watchdog_kick_op_i && !halt_op_i
        |=> $stable(flags_o[FLG_WDX])) else $error("watchdog flag moved");
    slp_set_a: assert property (
        halt_op_i && !watchdog_kick_op_i |=> flags_o[FLG_SLP])
        else $error("sleep flag not set");
    kick_clear_a: assert property (
        watchdog_kick_op_i && !watchdog_timeout_i
        |=> !flags_o[FLG_SLP] && !flags_o[FLG_WDX]) else $error("no clear");
    zero_flag_a: assert property (
        alu_i.valid && alu_i.op inside {SFR_OP_ADD, SFR_OP_SUB, SFR_OP_LOGIC}
        |=> flags_o[FLG_Z] == ($past(alu_i.res) == 8'h00))
        else $error("zero flag wrong");
    // interrupt gate and stack
    gate_clear_a: assert property (
        irq_enter_i && !irq_return_op_i ##1 !irq_return_op_i
        && !(acc_i.wr && acc_i.addr == ADR_IRQG) |=> !irq_req_o)
        else $error("request after entry");
    no_push_a: assert property (
        push_status_o == 1'b0) else $error("status pushed");
endmodule : sfr_core_chk

// file: testbench/sfr_mem_model.sv
// model: data memory and program memory beside the register core
`timescale 1ns/1ps
module sfr_mem_model import sfr_pkg::*; (
    input wire logic clk_i,
    input wire logic slow_i,
    input wire sfr_acc_t acc_i,
    input wire logic ram_wr_i,
    input wire logic [7:0] ram_addr_i,
    input wire logic [7:0] ram_wdata_i,
    input wire logic rom_rd_i,
    input wire logic [PC_W-1:0] rom_addr_i,
    output logic [7:0] ram_rdata_o,
    output logic [14:0] rom_data_o = '0,
    output logic rom_valid_o = 1'b0
);
    logic [7:0] mem [0:255];
    logic [7:0] ptr0 = 8'h00;
    logic [7:0] ptr1 = 8'h00;
    logic [7:0] last = 8'h00;
    logic [7:0] ea;
    logic [PC_W-1:0] radr = '0;
    int wait_n = -1;
    // shadow pointers so reads are answered in the access cycle
    assign ea = acc_i.addr == ADR_IND0 ? ptr0 :
        (acc_i.addr == ADR_IND1 ? ptr1 : acc_i.addr);
    assign ram_rdata_o = acc_i.rd ? mem[ea] : ~last;
    // storage, pointer snoop and last-read memory
    always @(posedge clk_i) begin
        if (acc_i.wr && acc_i.addr == ADR_PTR0) ptr0 <= acc_i.wdata;
        if (acc_i.wr && acc_i.addr == ADR_PTR1) ptr1 <= acc_i.wdata;
        if (ram_wr_i) mem[ram_addr_i] <= ram_wdata_i;
        if (acc_i.rd) last <= ram_rdata_o;
    end
    // program word after one or four cycles, data toggles when idle
    always @(posedge clk_i) begin
        rom_valid_o <= 1'b0;
        rom_data_o <= ~rom_data_o;
        if (rom_rd_i) begin
            radr <= rom_addr_i;
            wait_n <= slow_i ? 3 : 0;
        end else if (wait_n == 0) begin
            rom_valid_o <= 1'b1;
            rom_data_o <= {radr[6:0] ^ 7'h2A, radr[7:0] ^ 8'hC3};
            wait_n <= -1;
        end else if (wait_n > 0) begin
            wait_n <= wait_n - 1;
        end
    end
endmodule : sfr_mem_model

// file: testbench/tb_special_function_register_core.sv
// testbench: register core with memory model and checker
`timescale 1ns/1ps
module tb_special_function_register_core import sfr_pkg::*;;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    sfr_acc_t acc_i = '0;
    sfr_alu_t alu_i = '0;
    logic [PC_W-1:0] pc_i = '0;
    logic [7:0] table_dst_i = 8'h00;
    logic [5:0] ev = 6'h00;
    logic dst_wreg_i = 1'b0, pc_inc_i = 1'b0, table_fetch_cmd_i = 1'b0;
    logic table_dst_wreg_i = 1'b0, table_pointer_high_enable_i = 1'b0, slow = 1'b0;
    logic [14:0] rom_data_i;
    logic rom_valid_i, pc_load_o, dummy_cycle_o, rom_rd_o, ram_rd_o;
    logic ram_wr_o, irq_req_o, push_status_o;
    logic [7:0] ram_rdata_i, rdata_o, working_register_o, flags_o;
    logic [7:0] ram_addr_o, ram_wdata_o;
    logic [PC_W-1:0] pc_o, rom_addr_o;
    logic [BANK_W-1:0] ram_bank_o;
    logic [3:0] fl = 4'h0;
    int mismatches = 0;
    int num_checks = 0;
    int cyc = 0;
    sfr_core i_sfr_core (.*, .watchdog_kick_op_i(ev[0]), .halt_op_i(ev[1]),
        .watchdog_timeout_i(ev[2]), .irq_enter_i(ev[3]),
        .irq_return_op_i(ev[4]), .timer_overflow_i(ev[5]));
    sfr_mem_model i_sfr_mem_model (.clk_i, .slow_i(slow), .acc_i,
        .ram_wr_i(ram_wr_o), .ram_addr_i(ram_addr_o),
        .ram_wdata_i(ram_wdata_o), .rom_rd_i(rom_rd_o),
        .rom_addr_i(rom_addr_o), .ram_rdata_o(ram_rdata_i),
        .rom_data_o(rom_data_i), .rom_valid_o(rom_valid_i));
    // clock and hang guard
    always #5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 2000) begin
            mismatches++;
            $display("Error %0t: timeout", $time);
            end_sim();
        end
    end
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input logic [31:0] got, exp, input string what);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic tick();
        @(posedge clk_i);
        #1;
    endtask : tick
    task automatic acc(input logic r, w, input logic [7:0] a, d);
        tick();
        acc_i = '{r, w, a, d};
        tick();
        acc_i = '0;
    endtask : acc
    task automatic pulse(input int k);
        tick();
        ev[k] = 1'b1;
        tick();
        ev = 6'h00;
    endtask : pulse
    task automatic fetch(input logic w, input logic [7:0] d,
                         input logic [PC_W-1:0] ea);
        int n;
        tick();
        table_fetch_cmd_i = 1'b1;
        table_dst_wreg_i = w;
        table_dst_i = d;
        tick();
        table_fetch_cmd_i = 1'b0;
        chk({rom_rd_o, rom_addr_o}, {1'b1, ea}, "rom addr");
        n = 0;
        while (rom_valid_i !== 1'b1 && n < 20) begin
            tick();
            n++;
        end
        tick();
        tick();
    endtask : fetch
    task automatic step(input sfr_op_t op, input logic [7:0] a, b);
        logic sub;
        logic [7:0] bb, res, c7;
        logic [8:0] s;
        logic [4:0] h;
        sub = (op == SFR_OP_SUB);
        bb = sub ? ~b : b;
        s = {1'b0, a} + {1'b0, bb} + 9'(sub);
        h = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + 5'(sub);
        c7 = {1'b0, a[6:0]} + {1'b0, bb[6:0]} + 8'(sub);
        res = s[7:0];
        if (op == SFR_OP_LOGIC) res = a & b;
        if (op == SFR_OP_ROT) res = {a[6:0], fl[FLG_C]};
        if (op < SFR_OP_LOGIC) fl = {c7[7] ^ s[8], 1'b0, h[4], s[8]};
        if (op == SFR_OP_ROT) fl[FLG_C] = a[7];
        fl[FLG_Z] = (res == 8'h00);
        tick();
        alu_i = '{1'b1, op, a, b, res, (op == SFR_OP_ROT) ? a[7] : s[8]};
        dst_wreg_i = 1'b1;
        tick();
        alu_i = '0;
        dst_wreg_i = 1'b0;
        chk(flags_o[3:0], fl, "flags");
        chk(working_register_o, res, "result");
    endtask : step
    // pointers, indirect ports and the reserved gap
    task automatic t_ind();
        acc(0, 1, ADR_PTR0, 8'h45);
        acc(1, 0, ADR_PTR0, 8'h00);
        chk(rdata_o, 8'h45, "ptr0");
        acc(0, 1, ADR_IND0, 8'hA5);
        chk({ram_wr_o, ram_bank_o, ram_addr_o}, {1'b1, BANK0, 8'h45}, "i0");
        acc(1, 0, ADR_IND0, 8'h00);
        chk(rdata_o, 8'hA5, "i0 read");
        acc(0, 1, ADR_PTR1, 8'h50);
        acc(0, 1, ADR_IND1, 8'h3C);
        chk({ram_wr_o, ram_addr_o}, {1'b1, 8'h50}, "i1");
        acc(1, 0, 8'h50, 8'h00);
        chk(ram_rd_o, 1'b1, "ram read");
        chk(rdata_o, 8'h3C, "direct");
        acc(0, 1, ADR_PTR0, ADR_IND1);
        acc(0, 1, ADR_IND0, 8'h77);
        chk(ram_wr_o, 1'b0, "self write");
        acc(1, 0, ADR_IND0, 8'h00);
        chk(rdata_o, 8'h00, "self read");
        acc(1, 0, 8'h25, 8'h00);
        chk(rdata_o, 8'h00, "gap low");
        acc(1, 0, 8'h3F, 8'h00);
        chk(rdata_o, 8'h00, "gap high");
        $display("test indirect done");
    endtask : t_ind
    // low byte jump within the page
    task automatic t_pcl();
        tick();
        pc_i = 12'h7F0;
        pc_inc_i = 1'b1;
        tick();
        pc_inc_i = 1'b0;
        acc(0, 1, ADR_PCLB, 8'h12);
        chk({pc_o, pc_load_o, dummy_cycle_o}, {12'h712, 2'b11}, "jump");
        tick();
        chk({pc_load_o, dummy_cycle_o}, 2'b00, "one dummy");
        $display("test jump done");
    endtask : t_pcl
    // table reads with and without the high pointer
    task automatic t_tbl();
        acc(0, 1, ADR_TPLO, 8'h34);
        acc(0, 1, ADR_TPHI, 8'h0A);
        table_pointer_high_enable_i = 1'b1;
        fetch(1'b1, 8'h00, 12'hA34);
        chk(working_register_o, 8'h34 ^ 8'hC3, "low byte");
        acc(0, 1, ADR_TDHI, 8'h55);
        acc(1, 0, ADR_TDHI, 8'h00);
        chk(rdata_o, {1'b0, 7'h34 ^ 7'h2A}, "high byte");
        table_pointer_high_enable_i = 1'b0;
        slow = 1'b1;
        acc(0, 1, ADR_TPLO, 8'h81);
        fetch(1'b0, 8'h48, 12'h781);
        acc(1, 0, 8'h48, 8'h00);
        chk(rdata_o, 8'h81 ^ 8'hC3, "low to memory");
        acc(1, 0, ADR_TDHI, 8'h00);
        chk(rdata_o, {1'b0, 7'h01 ^ 7'h2A}, "high slow");
        $display("test table done");
    endtask : t_tbl
    // arithmetic flags and system flags
    task automatic t_flg();
        step(SFR_OP_ADD, 8'h80, 8'h80);
        step(SFR_OP_ADD, 8'h0F, 8'h01);
        step(SFR_OP_SUB, 8'h10, 8'h01);
        step(SFR_OP_SUB, 8'h80, 8'h01);
        step(SFR_OP_SUB, 8'h01, 8'h02);
        step(SFR_OP_LOGIC, 8'hF0, 8'h0F);
        step(SFR_OP_ROT, 8'h81, 8'h00);
        pulse(1);
        chk(flags_o[5:4], 2'b01, "halt");
        acc(0, 1, ADR_FLAG, 8'hF5);
        chk(flags_o[5:0], 6'h15, "flag write");
        pulse(2);
        chk(flags_o[5:4], 2'b11, "timeout");
        pulse(1);
        chk(flags_o[5:4], 2'b01, "halt clears");
        pulse(2);
        acc(0, 1, ADR_FLAG, 8'h00);
        chk(flags_o[5:0], 6'h30, "flag keep");
        pulse(0);
        chk(flags_o[5:4], 2'b00, "kick");
        $display("test flags done");
    endtask : t_flg
    // interrupt gate, enable and timer source
    task automatic t_irq();
        acc(0, 1, ADR_IRQG, 8'h01);
        pulse(5);
        tick();
        tick();
        chk(irq_req_o, 1'b0, "masked");
        acc(0, 1, ADR_IRQG, 8'h05);
        pulse(5);
        tick();
        chk(irq_req_o, 1'b1, "raised");
        pulse(3);
        tick();
        chk(irq_req_o, 1'b0, "gate off");
        acc(1, 0, ADR_IRQG, 8'h00);
        chk(rdata_o[IRQ_GATE], 1'b0, "entry");
        pulse(4);
        acc(1, 0, ADR_IRQG, 8'h00);
        chk({rdata_o[IRQ_TMR_EN], rdata_o[IRQ_GATE]}, 2'b11, "return");
        chk(push_status_o, 1'b0, "no push");
        $display("test interrupt done");
    endtask : t_irq
    // main sequence
    initial begin
        repeat (16) @(posedge clk_i);
        #1;
        reset_n_i = 1'b1;
        t_ind();
        t_pcl();
        t_tbl();
        t_flg();
        t_irq();
        end_sim();
    end
endmodule : tb_special_function_register_core
bind sfr_core sfr_core_chk i_sfr_core_chk (.*);
